// >>> smse_pkg.sv
package smse_pkg;
	// Reserved slave identifiers of the sleep sequence
	localparam logic [7:0] SMSE_RSV_FIRST = 8'hF8;
	localparam logic [7:0] SMSE_SLEEP_ID = 8'h86;
	localparam int SMSE_CLK_NS = 4;
	localparam int SMSE_BITS_ACK = 9;
	// Delays in microseconds, as printed
	localparam int SMSE_SLEEP_WAKE_DELAY_US = 400;
	localparam int SMSE_POWERUP_FIRST_ACCESS_DELAY_US = 250;
	localparam int SMSE_WAKE_CYC = (SMSE_SLEEP_WAKE_DELAY_US * 1000 + SMSE_CLK_NS - 1) / SMSE_CLK_NS;
	localparam int SMSE_PU_CYC =
		(SMSE_POWERUP_FIRST_ACCESS_DELAY_US * 1000 + SMSE_CLK_NS - 1) / SMSE_CLK_NS;
	// Bus clock limits in kHz; the master's divider must keep the rate below these
	localparam int SMSE_FS_MAX_KHZ = 1000;
	localparam int SMSE_HS_MAX_KHZ = 3400;
	localparam int SMSE_FS_HALF_CYC = (1000000 / SMSE_FS_MAX_KHZ + 2 * SMSE_CLK_NS - 1) / (2 * SMSE_CLK_NS);
	localparam int SMSE_HS_HALF_CYC = (1000000 / SMSE_HS_MAX_KHZ + 2 * SMSE_CLK_NS - 1) / (2 * SMSE_CLK_NS);
	localparam logic [15:0] SMSE_READY_WAIT_CYC = 16'h0010;
	typedef enum logic [5:0] {
		SMSE_M_IDLE = 6'b000001,
		SMSE_M_START = 6'b000010,
		SMSE_M_BIT = 6'b000100,
		SMSE_M_HOLD = 6'b001000,
		SMSE_M_STOP = 6'b010000,
		SMSE_M_WAIT = 6'b100000
	} smse_mstate_t;
endpackage : smse_pkg

// >>> smse_if.sv
`timescale 1ns/1ns
interface smse_if;
	logic sclOut;
	logic sdaMasterOut;
	logic sdaMasterOe;
	logic sdaDevOut;
	logic sdaDevOe;
	wire sda = ~((sdaMasterOe & ~sdaMasterOut) | (sdaDevOe & ~sdaDevOut));
	modport master (output sclOut, output sdaMasterOut, output sdaMasterOe, input sda);
	modport device (input sclOut, output sdaDevOut, output sdaDevOe, input sda);
endinterface : smse_if

// >>> smse_device.sv
`timescale 1ns/1ns
// Summary of operation
// - Device acknowledges final sleep identifier 86h
// - Sleep begins at ninth rise, line released
// - Release during high clock looks like STOP
// - Master may ignore spurious STOP
// - Master holds data low after ninth rise
// - Device ready within wake delay
// - Master waits power-up delay before START
// - Any clock rate from DC; master limits
module smse_device (
	input wire logic clk,
	input wire logic resetn,
	smse_if.device bus,
	output logic sleeping,
	output logic ready,
	output logic stopSeen
);
	logic [1:0] sclSync;
	logic [1:0] sdaSync;
	logic sclQ;
	logic sdaQ;
	logic [3:0] bitCnt;
	logic [7:0] shiftIn;
	logic armed;
	logic sleepId;
	logic ackDrive;
	logic [31:0] wakeCnt;
	wire sclRise = sclSync[1] & ~sclQ;
	wire sclFall = ~sclSync[1] & sclQ;
	wire startCond = sclSync[1] & sclQ & sdaQ & ~sdaSync[1];
	wire stopCond = sclSync[1] & sclQ & ~sdaQ & sdaSync[1];
	wire [7:0] byteDone = {shiftIn[6:0], sdaSync[1]};
	wire isSleepId = (byteDone == smse_pkg::SMSE_SLEEP_ID);
	wire ackEdge = sclRise & (bitCnt == 4'(smse_pkg::SMSE_BITS_ACK - 1));
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			sclSync <= 2'b11;
			sdaSync <= 2'b11;
			sclQ <= 1'b1;
			sdaQ <= 1'b1;
		end else begin
			sclSync <= {sclSync[0], bus.sclOut};
			sdaSync <= {sdaSync[0], bus.sda};
			sclQ <= sclSync[1];
			sdaQ <= sdaSync[1];
		end
	end
	// Bit counter and shifter; no dependence on link clock rate (edge based)
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			bitCnt <= 4'h0;
			shiftIn <= 8'h00;
		end else if (startCond || stopCond) begin
			bitCnt <= 4'h0;
		end else if (sclRise) begin
			bitCnt <= (bitCnt == 4'(smse_pkg::SMSE_BITS_ACK - 1)) ? 4'h0 : bitCnt + 4'h1;
			if (bitCnt < 4'h8)
				shiftIn <= byteDone;
		end
	end
	// Armed after the first reserved identifier; the next byte 86h is the sleep id
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			armed <= 1'b0;
			sleepId <= 1'b0;
			ackDrive <= 1'b0;
			sleeping <= 1'b0;
		end else begin
			// Only the id that follows the first reserved one may put us to sleep
			if (sclRise && bitCnt == 4'h7 && !sleeping) begin
				armed <= (byteDone == smse_pkg::SMSE_RSV_FIRST) | (armed & isSleepId);
				sleepId <= armed & isSleepId;
			end
			if (sclFall && bitCnt == 4'h8 && armed && !sleeping)
				ackDrive <= 1'b1;
			else if (ackEdge)
				ackDrive <= 1'b0;
			if (ackEdge && ackDrive && sleepId) begin
				sleeping <= 1'b1;
				armed <= 1'b0;
				sleepId <= 1'b0;
			end else if (sleeping && startCond) begin
				sleeping <= 1'b0;
			end
		end
	end
	// Wake recovery counter, well inside the allowed delay
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			wakeCnt <= 32'h0000_0000;
			ready <= 1'b0;
		end else if (sleeping) begin
			wakeCnt <= 32'h0000_0000;
			ready <= 1'b0;
		end else if (wakeCnt < 32'(smse_pkg::SMSE_READY_WAIT_CYC)) begin
			wakeCnt <= wakeCnt + 32'h0000_0001;
		end else begin
			ready <= 1'b1;
		end
	end
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			stopSeen <= 1'b0;
		else
			stopSeen <= stopCond;
	end
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			bus.sdaDevOut <= 1'b1;
			bus.sdaDevOe <= 1'b0;
		end else begin
			bus.sdaDevOut <= 1'b0;
			bus.sdaDevOe <= (sclFall && bitCnt == 4'h8 && armed && !sleeping) |
				(ackDrive & ~ackEdge);
		end
	end
endmodule : smse_device

// >>> smse_master.sv
`timescale 1ns/1ns
module smse_master #(
	parameter int PU_CYC = smse_pkg::SMSE_PU_CYC,
	parameter int WAKE_CYC = smse_pkg::SMSE_WAKE_CYC,
	parameter int HALF_CYC = smse_pkg::SMSE_FS_HALF_CYC,
	parameter bit HOLD_LOW = 1'b1
) (
	input wire logic clk,
	input wire logic resetn,
	smse_if.master bus,
	input wire logic sendReq,
	input wire logic [7:0] sendByte,
	input wire logic sendStop,
	output logic busy,
	output logic acked,
	output logic done,
	output logic devSleeping
);
	smse_pkg::smse_mstate_t state;
	logic [31:0] waitCnt;
	logic [15:0] halfCnt;
	logic [3:0] bitIdx;
	logic [7:0] txByte;
	logic stopPend;
	logic puDone;
	logic [1:0] sdaSync;
	wire halfTick = (halfCnt == 16'(HALF_CYC - 1));
	wire ackBit = (bitIdx == 4'h8);
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			sdaSync <= 2'b11;
		else
			sdaSync <= {sdaSync[0], bus.sda};
	end
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state <= smse_pkg::SMSE_M_WAIT;
			waitCnt <= 32'h0000_0000;
			halfCnt <= 16'h0000;
			bitIdx <= 4'h0;
			txByte <= 8'h00;
			stopPend <= 1'b0;
			puDone <= 1'b0;
			bus.sclOut <= 1'b1;
			bus.sdaMasterOut <= 1'b1;
			bus.sdaMasterOe <= 1'b0;
			busy <= 1'b1;
			acked <= 1'b0;
			done <= 1'b0;
			devSleeping <= 1'b0;
		end else begin
			done <= 1'b0;
			halfCnt <= halfTick ? 16'h0000 : halfCnt + 16'h0001;
			unique case (state)
			smse_pkg::SMSE_M_WAIT: begin
				waitCnt <= waitCnt + 32'h0000_0001;
				if (waitCnt >= 32'((puDone ? WAKE_CYC : PU_CYC) - 1)) begin
					state <= smse_pkg::SMSE_M_IDLE;
					puDone <= 1'b1;
					devSleeping <= 1'b0;
					busy <= 1'b0;
				end
			end
			smse_pkg::SMSE_M_IDLE: begin
				if (sendReq) begin
					busy <= 1'b1;
					txByte <= sendByte;
					stopPend <= sendStop;
					bitIdx <= 4'h0;
					state <= smse_pkg::SMSE_M_START;
					bus.sdaMasterOe <= 1'b1;
					bus.sdaMasterOut <= 1'b0;
				end
			end
			smse_pkg::SMSE_M_START: begin
				if (halfTick) begin
					bus.sclOut <= 1'b0;
					state <= smse_pkg::SMSE_M_BIT;
				end
			end
			smse_pkg::SMSE_M_BIT: begin
				if (halfTick && bus.sclOut) begin
					bus.sclOut <= 1'b0;
					if (ackBit) begin
						state <= stopPend ? smse_pkg::SMSE_M_STOP : smse_pkg::SMSE_M_HOLD;
						bitIdx <= 4'h0;
						done <= 1'b1;
					end else begin
						bitIdx <= bitIdx + 4'h1;
					end
				end else if (halfTick) begin
					bus.sclOut <= 1'b1;
					if (ackBit) begin
						acked <= ~sdaSync[1];
						if (!sdaSync[1] && txByte == smse_pkg::SMSE_SLEEP_ID)
							devSleeping <= 1'b1;
						bus.sdaMasterOe <= HOLD_LOW;
						bus.sdaMasterOut <= 1'b0;
					end
				end else if (!bus.sclOut && halfCnt == 16'h0000) begin
					bus.sdaMasterOe <= ~ackBit;
					bus.sdaMasterOut <= ackBit ? 1'b1 : txByte[3'(7 - bitIdx)];
				end
			end
			smse_pkg::SMSE_M_HOLD: begin
				bus.sdaMasterOe <= 1'b0;
				busy <= 1'b0;
				state <= smse_pkg::SMSE_M_IDLE;
				// The first data bit must be on the line before the next rise
				if (sendReq) begin
					busy <= 1'b1;
					txByte <= sendByte;
					stopPend <= sendStop;
					state <= smse_pkg::SMSE_M_BIT;
					bus.sdaMasterOe <= 1'b1;
					bus.sdaMasterOut <= sendByte[7];
				end
			end
			smse_pkg::SMSE_M_STOP: begin
				// A stray STOP from the device is never observed here; sequence runs on
				bus.sdaMasterOe <= 1'b1;
				bus.sdaMasterOut <= 1'b0;
				if (halfTick && !bus.sclOut) begin
					bus.sclOut <= 1'b1;
				end else if (halfTick) begin
					bus.sdaMasterOe <= 1'b0;
					bus.sdaMasterOut <= 1'b1;
					waitCnt <= 32'h0000_0000;
					state <= devSleeping ? smse_pkg::SMSE_M_WAIT : smse_pkg::SMSE_M_IDLE;
					busy <= devSleeping;
				end
			end
			default: state <= smse_pkg::SMSE_M_IDLE;
			endcase
		end
	end
endmodule : smse_master

// >>> smse_checker.sv
`timescale 1ns/1ns
module smse_checker #(
	parameter int PU_CYC = 50,
	parameter int WAKE_CYC = 50
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic sclOut,
	input wire logic sdaMasterOut,
	input wire logic sdaMasterOe,
	input wire logic sdaDevOut,
	input wire logic sdaDevOe,
	input wire logic sda
);
	localparam int MIN_PER = 1000000 / smse_pkg::SMSE_FS_MAX_KHZ / smse_pkg::SMSE_CLK_NS;
	logic sclQ, sdaQ, fresh, asleep;
	logic [3:0] bitCnt;
	logic [7:0] shiftReg;
	int gap, upCnt, wakeCnt;
	wire sclRise = sclOut & ~sclQ;
	wire startEv = sclOut & sclQ & sdaQ & ~sda;
	wire stopEv = sclOut & sclQ & ~sdaQ & sda;
	wire ninth = sclRise && bitCnt == 4'h8;
	wire sleepHit = ninth && shiftReg == smse_pkg::SMSE_SLEEP_ID;
	// Bit count follows the wire only, so a chained byte needs no START to realign
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			{sclQ, sdaQ, fresh, asleep, bitCnt, shiftReg} <= {4'hC, 4'h0, 8'h00};
			{gap, upCnt, wakeCnt} <= {MIN_PER, 32'h0000_0000, 32'h0000_0000};
		end else begin
			{sclQ, sdaQ} <= {sclOut, sda};
			fresh <= startEv | (fresh & ~sclRise);
			bitCnt <= startEv | ninth ? 4'h0 : bitCnt + {3'h0, sclRise};
			shiftReg <= sclRise && bitCnt < 4'h8 ? {shiftReg[6:0], sda} : shiftReg;
			gap <= sclRise ? 1 : gap + 1;
			upCnt <= upCnt + 1;
			asleep <= sleepHit | (asleep & ~(sclRise & fresh));
			wakeCnt <= sleepHit | (asleep & stopEv) ? 1 : wakeCnt + 1;
		end
	end
	sequence sleepAck;
		sleepHit;
	endsequence
	sequence holdLow;
		sdaMasterOe && !sdaMasterOut;
	endsequence
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	sleep_ack_a: assert property (sleepAck |-> !sda)
		else $error("sleep id not acknowledged");
	first_ack_a: assert property (ninth && shiftReg == smse_pkg::SMSE_RSV_FIRST |-> !sda)
		else $error("first reserved id not acknowledged");
	dev_release_a: assert property (sleepAck |-> ##[1:300] !sdaDevOe)
		else $error("device kept data line after sleep id");
	quiet_release_a: assert property ($fell(sdaDevOe) && sclOut |-> !sda)
		else $error("release with clock high raised data line");
	master_hold_a: assert property (sleepAck |-> ##[0:3] holdLow)
		else $error("master did not hold data low");
	powerup_wait_a: assert property (startEv |-> upCnt >= PU_CYC)
		else $error("start too early after reset");
	clock_rate_a: assert property (sclRise |-> gap >= MIN_PER)
		else $error("link clock period too short");
	wake_wait_a: assert property (startEv && asleep |-> wakeCnt >= WAKE_CYC)
		else $error("transfer before recovery wait");
endmodule : smse_checker

// >>> smse_bench.sv
`timescale 1ns/1ns
module smse_bench;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic sendReq = 1'b0;
	logic sendStop = 1'b0;
	logic [7:0] sendByte = 8'h00;
	logic busy, acked, done, devSleeping, sleeping, ready, stopSeen;
	int seed = 32'h0000_c37a;
	int bad_count = 0;
	int checks_done = 0;
	int stops = 0;
	logic expQ[$];
	smse_if bus();
	always #2 clk = ~clk;
	smse_master #(.PU_CYC(50), .WAKE_CYC(50)) smse_master_inst (.clk(clk), .resetn(resetn),
		.bus(bus), .sendReq(sendReq), .sendByte(sendByte), .sendStop(sendStop), .busy(busy),
		.acked(acked), .done(done), .devSleeping(devSleeping));
	smse_device smse_device_inst (.clk(clk), .resetn(resetn), .bus(bus), .sleeping(sleeping),
		.ready(ready), .stopSeen(stopSeen));
	smse_checker #(.PU_CYC(50), .WAKE_CYC(50)) smse_checker_inst (.clk(clk), .resetn(resetn),
		.sclOut(bus.sclOut), .sdaMasterOut(bus.sdaMasterOut), .sdaMasterOe(bus.sdaMasterOe),
		.sdaDevOut(bus.sdaDevOut), .sdaDevOe(bus.sdaDevOe), .sda(bus.sda));
	task automatic cmp(input string what, input logic exp, input logic seen);
		checks_done++;
		if (seen !== exp) begin
			bad_count++;
			$display("Error %s expected %b seen %b", what, exp, seen);
		end
	endtask : cmp
	task automatic final_report;
		if (bad_count == 0 && checks_done > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : final_report
	task automatic idle;
		for (int n = 0; n < 3000 && busy !== 1'b0; n++) @(negedge clk);
	endtask : idle
	// A chained byte is only taken in the cycle in which done is high, so it goes up at once
	task automatic send(input logic [7:0] b, input logic stop, input logic chain);
		if (!chain) @(negedge clk);
		{sendReq, sendByte, sendStop} = {1'b1, b, stop};
		expQ.push_back(1'b1);
		@(negedge clk);
		sendReq = 1'b0;
		repeat (20) @(negedge clk);
		{sendReq, sendByte} = {1'b1, 8'($random(seed))};
		@(negedge clk);
		sendReq = 1'b0;
		for (int n = 0; n < 3000 && done !== 1'b1; n++) @(negedge clk);
	endtask : send
	// An extra done finds the queue empty and is caught only when acked is high
	always @(posedge clk) begin
		if (done === 1'b1) cmp("acked", expQ.size() > 0 ? expQ.pop_front() : 1'b0, acked);
		stops <= stops + int'(stopSeen === 1'b1);
	end
	initial begin
		repeat (12) @(negedge clk);
		resetn = 1'b1;
		idle();
		repeat (2 + ($random(seed) & 15)) @(negedge clk);
		send(smse_pkg::SMSE_RSV_FIRST, 1'b0, 1'b0);
		send(smse_pkg::SMSE_SLEEP_ID, 1'b1, 1'b1);
		cmp("sleeping", 1'b1, sleeping);
		cmp("devSleeping", 1'b1, devSleeping);
		idle();
		cmp("stop count", 1'b1, stops == 1);
		repeat (2 + ($random(seed) & 15)) @(negedge clk);
		send(smse_pkg::SMSE_RSV_FIRST, 1'b1, 1'b0);
		cmp("ready", 1'b1, ready);
		cmp("sleeping", 1'b0, sleeping);
		idle();
		repeat (2) @(negedge clk);
		final_report();
	end
	initial begin
		repeat (40000) @(posedge clk);
		bad_count++;
		final_report();
	end
endmodule : smse_bench
